/* File: bench/sps_chk_sva.sv */
`timescale 1ns/100ps
`include "sps_regs.vh"
module sps_chk
(
  // clock and reset
  input logic        clk_sys,
  input logic        rst,
  // register bus
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // link and levels
  input logic        portBBit1ClockPinOut,
  input logic        portBBit1ClockPinOe,
  input logic [1:0]  irqLevelA,
  input logic [1:0]  irqLevelB
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [3:0] highRun;
  logic [3:0] falls;
  // high run saturates; a long one means the own clock is idle
  always @(posedge clk_sys)
  begin
    if (rst || !portBBit1ClockPinOut)
      highRun <= 4'h0;
    else if (highRun != 4'hf)
      highRun <= highRun + 4'h1;
  end
  // falls per frame; first fall after idle restarts the count
  always @(posedge clk_sys)
  begin
    if (rst)
      falls <= 4'h0;
    else if (portBBit1ClockPinOe && $fell(portBBit1ClockPinOut))
      falls <= (highRun > 4'h6) ? 4'h1 : falls + 4'h1;
  end
  function automatic logic isReg(input logic [7:0] a);
    return a inside {8'hc0, 8'hc4, 8'hc8, 8'hd0, 8'hd4, 8'hd8};
  endfunction
  sequence s_bAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_lowPhase;
    (!portBBit1ClockPinOut)[*4] ##1 portBBit1ClockPinOut;
  endsequence
  AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_bAnswer) else $error("write answer out of place");
  AST_WR_MAPPED: assert property (s_axi_awvalid && s_axi_awready && isReg(s_axi_awaddr)
    |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == `SPS_RESP_OKAY)) else $error("write not okay");
  AST_WR_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && !isReg(s_axi_awaddr)
    |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == `SPS_RESP_SLVERR)) else $error("no write error");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && !isReg(s_axi_araddr)
    |=> s_axi_rvalid && s_axi_rresp == `SPS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("bad unmapped read");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_IRQ_LEGAL: assert property (irqLevelA != 2'h3 && irqLevelB != 2'h3)
    else $error("illegal interrupt level");
  AST_OWN_HALF: assert property (portBBit1ClockPinOe && $fell(portBBit1ClockPinOut)
    |-> s_lowPhase) else $error("own clock low phase wrong");
  AST_OWN_EIGHT: assert property (falls <= 4'h8)
    else $error("more than eight clocks in a frame");
endmodule

bind sps_serial_ctrl sps_chk u_chk (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .portBBit1ClockPinOut, .portBBit1ClockPinOe, .irqLevelA, .irqLevelB);

/* File: bench/sps_ext_dev.sv */
`timescale 1ns/100ps
module sps_ext_dev
(
  // frame control
  input  logic       run,
  input  logic       load,
  input  logic [7:0] sendByte,
  // link
  input  logic       sclk,
  input  logic       txd,
  output logic       extClk,
  output logic       rxd,
  output logic [7:0] gotByte,
  output logic [3:0] edges
);
  logic [7:0] shift;
  // clock stands high between frames
  initial extClk = 1'b1;
  // eight periods of 800 ns per frame, started by the bench
  always @(posedge run)
  begin
    repeat (8)
    begin
      #400 extClk = 1'b0;
      #400 extClk = 1'b1;
    end
  end
  // new byte to send, edge counter cleared
  always @(posedge load)
  begin
    shift = sendByte;
    edges = 4'h0;
  end
  // sample the port's data on each rising edge, lsb first
  always @(posedge sclk)
  begin
    gotByte = {txd, gotByte[7:1]};
    edges = edges + 4'h1;
  end
  // next bit after a fall; used bits come back inverted so a stale line shows
  always @(negedge sclk)
  begin
    if (edges != 4'h0)
      shift = {~shift[0], shift[7:1]};
  end
  assign rxd = shift[0];
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
`include "sps_regs.vh"
module tb;
  logic        clk_sys, rst, run, load, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_arready, s_axi_rvalid, txdA, txdB, portBBit0ClockPinOut;
  logic        portBBit1ClockPinOut, portBBit1ClockPinOe, portBBit0ClockPinOe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sendByte, gotByte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, edges;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irqLevelA, irqLevelB, srcSel;
  wire         extClk, rxd;
  wire         portBBit1ClockPinIn = portBBit1ClockPinOe ? portBBit1ClockPinOut : extClk;
  wire         rxPortCA = (srcSel == 2'h0) ? rxd : ~rxd;
  wire         rxPortDA = (srcSel == 2'h1) ? rxd : ~rxd;
  int          num_errors, checked;

  sps_serial_ctrl dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .portBBit1ClockPinIn, .portBBit1ClockPinOut,
    .portBBit1ClockPinOe, .txdA, .rxPortCA, .rxPortDA, .irqLevelA,
    .portBBit0ClockPinIn(1'b1), .portBBit0ClockPinOut, .portBBit0ClockPinOe, .txdB,
    .rxPortCB(1'b1), .rxPortDB(1'b1), .irqLevelB);
  sps_ext_dev dev (.run, .load, .sendByte, .sclk(portBBit1ClockPinIn), .txd(txdA), .extClk,
    .rxd, .gotByte, .edges);

  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bready and rready stay high, so no edge sees one lowered and raised at once
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no limit of its own; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // data taken at the same edge that shows rvalid high
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task dev_load(input logic [7:0] b);
    sendByte <= b;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  // one command per byte; waits for done, then reading the byte clears done
  task automatic run_cmd(input logic [7:0] c, input logic [7:0] b, output logic [31:0] d);
    logic [1:0] r;
    dev_load(b);
    axi_write(`SPS_ADDR_A_CTRL, c, r);
    if (c[3:2] == `SPS_MODE_EXTCLK)
    begin
      run <= 1'b1;
      @(posedge clk_sys);
      run <= 1'b0;
    end
    d = 32'h0;
    for (int n = 0; n < 60 && d[1] !== 1'b1; n++)
      axi_read(`SPS_ADDR_A_STAT, d, r);
    check("done", 1'b1, d[1]);
    axi_read(`SPS_ADDR_A_DATA, d, r);
    check("edges", 8, edges);
  endtask
  task test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(`SPS_ADDR_A_CTRL, d, r);
    check("ctrlA reset", `SPS_CTRL_RESET, d);
    axi_read(`SPS_ADDR_B_CTRL, d, r);
    check("ctrlB reset", `SPS_CTRL_RESET, d);
    axi_write(8'h40, 8'h0f, r);
    check("wr unmapped", `SPS_RESP_SLVERR, r);
    axi_read(8'h40, d, r);
    check("rd unmapped", `SPS_RESP_SLVERR, r);
    $display("test_regs done");
  endtask
  // async modes: command field ignored, other fields kept
  task test_fields;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    for (int i = 0; i < 4; i++)
    begin
      c = {2'h3, i[1:0], 1'b0, i[0], i[1:0]};
      axi_write(`SPS_ADDR_B_CTRL, c, r);
      axi_read(`SPS_ADDR_B_CTRL, d, r);
      check("ctrlB", {26'h0, c[5:0]}, d);
      check("irqB", (i == 3) ? 2'h0 : i[1:0], irqLevelB);
      axi_read(`SPS_ADDR_B_STAT, d, r);
      check("statB idle", 0, d);
      check("portB link", 3'b101, {txdB, portBBit0ClockPinOe, portBBit0ClockPinOut});
    end
    $display("test_fields done");
  endtask
  task test_nop;
    logic [31:0] d;
    logic [1:0]  r;
    dev_load(8'h00);
    axi_write(`SPS_ADDR_A_CTRL, {`SPS_CMD_NOP, `SPS_SRC_PORTC, `SPS_MODE_INTCLK, 2'h0}, r);
    // longer than one whole frame
    repeat (80) @(posedge clk_sys);
    check("nop edges", 0, edges);
    check("clkA oe", 1'b1, portBBit1ClockPinOe);
    axi_read(`SPS_ADDR_A_STAT, d, r);
    check("nop stat", 0, d);
    $display("test_nop done");
  endtask
  task test_duplex;
    logic [31:0] d;
    logic [1:0]  r;
    srcSel <= `SPS_SRC_PORTC;
    axi_write(`SPS_ADDR_A_DATA, 8'ha5, r);
    // duplex by one combined command, never two separate ones
    run_cmd({`SPS_CMD_TXRX, `SPS_SRC_PORTC, `SPS_MODE_INTCLK, 2'h0}, 8'h3c, d);
    check("rx", 8'h3c, d);
    check("dev got", 8'ha5, gotByte);
    check("txd idle", 1'b1, txdA);
    $display("test_duplex done");
  endtask
  task test_ext;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`SPS_ADDR_A_DATA, 8'h5a, r);
    run_cmd({`SPS_CMD_TX, `SPS_SRC_PORTC, `SPS_MODE_EXTCLK, `SPS_INT_PRIO1}, 8'h99, d);
    check("dev got", 8'h5a, gotByte);
    check("rx kept", 8'h3c, d);
    check("irqA", `SPS_INT_PRIO1, irqLevelA);
    check("clkA oe ext", 1'b0, portBBit1ClockPinOe);
    srcSel <= `SPS_SRC_PORTD;
    run_cmd({`SPS_CMD_RX, `SPS_SRC_PORTD, `SPS_MODE_EXTCLK, `SPS_INT_PRIO2}, 8'hc3, d);
    check("rx portD", 8'hc3, d);
    check("txd quiet", 8'hff, gotByte);
    $display("test_ext done");
  endtask
  task test_seven;
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(`SPS_ADDR_A_CTRL, {`SPS_CMD_TXRX, `SPS_SRC_PORTC, `SPS_MODE_ASYNC7, 2'h0}, r);
    axi_read(`SPS_ADDR_A_DATA, d, r);
    check("rx 7bit", 8'h43, d);
    axi_write(`SPS_ADDR_A_DATA, 8'ha5, r);
    run_cmd({`SPS_CMD_TXRX, 2'h2, `SPS_MODE_INTCLK, 2'h0}, 8'h00, d);
    check("tx 7bit", 8'h25, gotByte);
    check("rx off", 8'hff, d);
    $display("test_seven done");
  endtask
  // main sequence
  initial
  begin
    {rst, s_axi_bready, s_axi_rready} = 3'h7;
    {run, load, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, sendByte, srcSel} = 26'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    test_regs;
    test_fields;
    test_nop;
    test_duplex;
    test_ext;
    test_seven;
    report_and_stop;
  end
  // watchdog, well past the expected few hundred cycles
  initial
  begin
    #2000000;
    num_errors++;
    $display("BAD watchdog expected finish seen hang");
    report_and_stop;
  end
endmodule

/* File: hdl/sps_regs.vh */
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// register byte addresses
`define SPS_ADDR_A_DATA   8'hc0
`define SPS_ADDR_A_CTRL   8'hc4
`define SPS_ADDR_A_STAT   8'hc8
`define SPS_ADDR_B_DATA   8'hd0
`define SPS_ADDR_B_CTRL   8'hd4
`define SPS_ADDR_B_STAT   8'hd8

// control register fields
`define SPS_CMD_HI        7
`define SPS_CMD_LO        6
`define SPS_SRC_HI        5
`define SPS_SRC_LO        4
`define SPS_MODE_HI       3
`define SPS_MODE_LO       2
`define SPS_INT_HI        1
`define SPS_INT_LO        0

// command codes
`define SPS_CMD_NOP       2'h0
`define SPS_CMD_RX        2'h1
`define SPS_CMD_TX        2'h2
`define SPS_CMD_TXRX      2'h3

// mode codes
`define SPS_MODE_ASYNC8   2'h0
`define SPS_MODE_ASYNC7   2'h1
`define SPS_MODE_EXTCLK   2'h2
`define SPS_MODE_INTCLK   2'h3

// receiver source codes
`define SPS_SRC_PORTC     2'h0
`define SPS_SRC_PORTD     2'h1

// interrupt codes
`define SPS_INT_OFF       2'h0
`define SPS_INT_PRIO1     2'h1
`define SPS_INT_PRIO2     2'h2

// status bits
`define SPS_STAT_BUSY     0
`define SPS_STAT_DONE     1

// reset values
`define SPS_CTRL_RESET    8'h00
`define SPS_DATA_RESET    8'h00

// timing
`define SPS_CLK_NS        100
`define SPS_BIT_TIME_NS   800
`define SPS_BITS_PER_CMD  4'h8

// bus responses
`define SPS_RESP_OKAY     2'h0
`define SPS_RESP_SLVERR   2'h2

`endif

/* File: hdl/sps_serial_ctrl.v */
`timescale 1ns/100ps
`include "sps_regs.vh"

module sps_serial_ctrl
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial port a link
  input  wire        portBBit1ClockPinIn,
  output wire        portBBit1ClockPinOut,
  output wire        portBBit1ClockPinOe,
  output wire        txdA,
  input  wire        rxPortCA,
  input  wire        rxPortDA,
  output reg  [1:0]  irqLevelA,
  // serial port b link
  input  wire        portBBit0ClockPinIn,
  output wire        portBBit0ClockPinOut,
  output wire        portBBit0ClockPinOe,
  output wire        txdB,
  input  wire        rxPortCB,
  input  wire        rxPortDB,
  output reg  [1:0]  irqLevelB
);

  // half of the serial bit time in system clocks, never below one
  localparam integer HALF_RAW = (`SPS_BIT_TIME_NS / 2) / `SPS_CLK_NS;
  localparam [15:0]  HALF_CYCLES = (HALF_RAW < 1) ? 16'h0001 : HALF_RAW[15:0];

  // control, transmit data and status per port
  reg  [7:0]  ctrlA;
  reg  [7:0]  ctrlB;
  reg  [7:0]  txDataA;
  reg  [7:0]  txDataB;
  reg         doneFlagA;
  reg         doneFlagB;
  reg         startA;
  reg         startB;
  reg         goTxA;
  reg         goRxA;
  reg         goTxB;
  reg         goRxB;
  // write channel holding registers
  reg  [7:0]  awAddr;
  reg         awHeld;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         wHeld;
  // receive pin synchronisers
  reg  [3:0]  rxS1;
  reg  [3:0]  rxS2;
  // engine results
  wire        busyA;
  wire        busyB;
  wire        doneA;
  wire        doneB;
  wire [7:0]  rxByteA;
  wire [7:0]  rxByteB;

  // clocked modes are the only ones that accept commands
  function isClocked;
    input [7:0] ctrl;
    begin
      isClocked = ctrl[`SPS_MODE_HI];
    end
  endfunction

  // receive input by source select; disabled input idles high
  function rxPick;
    input [7:0] ctrl;
    input       pinC;
    input       pinD;
    begin
      if (ctrl[`SPS_SRC_HI])
        rxPick = 1'b1;
      else if (ctrl[`SPS_SRC_LO])
        rxPick = pinD;
      else
        rxPick = pinC;
    end
  endfunction

  // seven-bit mode clears the top bit of a character
  function [7:0] charView;
    input [7:0] ctrl;
    input [7:0] data;
    begin
      if (ctrl[`SPS_MODE_HI:`SPS_MODE_LO] == `SPS_MODE_ASYNC7)
        charView = {1'b0, data[6:0]};
      else
        charView = data;
    end
  endfunction

  // interrupt level; the undefined code 11 is treated as off
  function [1:0] irqOf;
    input [7:0] ctrl;
    begin
      case (ctrl[`SPS_INT_HI:`SPS_INT_LO])
        `SPS_INT_PRIO1: irqOf = `SPS_INT_PRIO1;
        `SPS_INT_PRIO2: irqOf = `SPS_INT_PRIO2;
        default:        irqOf = `SPS_INT_OFF;
      endcase
    end
  endfunction

  // two flops on every receive pin before the source mux reads them
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxS1 <= 4'hf;
      rxS2 <= 4'hf;
    end
    else
    begin
      rxS1 <= {rxPortDB, rxPortCB, rxPortDA, rxPortCA};
      rxS2 <= rxS1;
    end
  end

  wire readTake = s_axi_arvalid & s_axi_arready;
  wire bothHeld = awHeld & wHeld & ~s_axi_bvalid;
  wire wrLane0  = wStrb[0];
  wire wrCtrlA  = bothHeld & wrLane0 & (awAddr == `SPS_ADDR_A_CTRL);
  wire wrCtrlB  = bothHeld & wrLane0 & (awAddr == `SPS_ADDR_B_CTRL);
  wire [1:0] cmdIn = wData[`SPS_CMD_HI:`SPS_CMD_LO];

  // write channel: address and data taken in either order
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPS_RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!s_axi_awready && !awHeld && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!s_axi_wready && !wHeld && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      // response follows both halves
      if (bothHeld)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr)
          `SPS_ADDR_A_DATA, `SPS_ADDR_A_CTRL, `SPS_ADDR_A_STAT,
          `SPS_ADDR_B_DATA, `SPS_ADDR_B_CTRL, `SPS_ADDR_B_STAT:
            s_axi_bresp <= `SPS_RESP_OKAY;
          default:
            s_axi_bresp <= `SPS_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register file; command bits are not stored, they fire a start
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlA     <= `SPS_CTRL_RESET;
      ctrlB     <= `SPS_CTRL_RESET;
      txDataA   <= `SPS_DATA_RESET;
      txDataB   <= `SPS_DATA_RESET;
      doneFlagA <= 1'b0;
      doneFlagB <= 1'b0;
      startA    <= 1'b0;
      startB    <= 1'b0;
      goTxA     <= 1'b0;
      goRxA     <= 1'b0;
      goTxB     <= 1'b0;
      goRxB     <= 1'b0;
      irqLevelA <= `SPS_INT_OFF;
      irqLevelB <= `SPS_INT_OFF;
    end
    else
    begin
      startA    <= 1'b0;
      startB    <= 1'b0;
      irqLevelA <= irqOf(ctrlA);
      irqLevelB <= irqOf(ctrlB);
      if (bothHeld && wrLane0 && awAddr == `SPS_ADDR_A_DATA)
        txDataA <= charView(ctrlA, wData[7:0]);
      if (bothHeld && wrLane0 && awAddr == `SPS_ADDR_B_DATA)
        txDataB <= charView(ctrlB, wData[7:0]);
      if (wrCtrlA)
      begin
        ctrlA <= {2'b00, wData[5:0]};
        // a command while busy or in async mode is dropped
        if (isClocked(wData[7:0]) && cmdIn != `SPS_CMD_NOP && !busyA)
        begin
          startA <= 1'b1;
          goTxA  <= cmdIn[1];
          goRxA  <= cmdIn[0];
        end
      end
      if (wrCtrlB)
      begin
        ctrlB <= {2'b00, wData[5:0]};
        if (isClocked(wData[7:0]) && cmdIn != `SPS_CMD_NOP && !busyB)
        begin
          startB <= 1'b1;
          goTxB  <= cmdIn[1];
          goRxB  <= cmdIn[0];
        end
      end
      // done is cleared by reading the data register; a new done wins
      if (readTake && s_axi_araddr == `SPS_ADDR_A_DATA)
        doneFlagA <= 1'b0;
      if (doneA)
        doneFlagA <= 1'b1;
      if (readTake && s_axi_araddr == `SPS_ADDR_B_DATA)
        doneFlagB <= 1'b0;
      if (doneB)
        doneFlagB <= 1'b1;
    end
  end

  // read channel: one-cycle answer, unmapped reads give slverr
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SPS_RESP_OKAY;
    end
    else
    begin
      if (readTake)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `SPS_RESP_OKAY;
        case (s_axi_araddr)
          `SPS_ADDR_A_DATA: s_axi_rdata <= {24'h000000, charView(ctrlA, rxByteA)};
          `SPS_ADDR_A_CTRL: s_axi_rdata <= {24'h000000, ctrlA};
          `SPS_ADDR_A_STAT: s_axi_rdata <= {30'h00000000, doneFlagA, busyA};
          `SPS_ADDR_B_DATA: s_axi_rdata <= {24'h000000, charView(ctrlB, rxByteB)};
          `SPS_ADDR_B_CTRL: s_axi_rdata <= {24'h000000, ctrlB};
          `SPS_ADDR_B_STAT: s_axi_rdata <= {30'h00000000, doneFlagB, busyB};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPS_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_arready && !s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // port a engine; its clock sits on port b bit 1
  sps_shift_engine
  #(
    .HALF_CYCLES (HALF_CYCLES),
    .BITS        (`SPS_BITS_PER_CMD)
  )
  u_engine_a
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .startCmd  (startA),
    .doTx      (goTxA),
    .doRx      (goRxA),
    .intClock  (ctrlA[`SPS_MODE_HI:`SPS_MODE_LO] == `SPS_MODE_INTCLK),
    .txByte    (txDataA),
    .busy      (busyA),
    .done      (doneA),
    .rxByte    (rxByteA),
    .clkPinIn  (portBBit1ClockPinIn),
    .rxIn      (rxPick(ctrlA, rxS2[0], rxS2[1])),
    .txd       (txdA),
    .clkPinOut (portBBit1ClockPinOut),
    .clkPinOe  (portBBit1ClockPinOe)
  );

  // port b engine; its clock sits on port b bit 0
  sps_shift_engine
  #(
    .HALF_CYCLES (HALF_CYCLES),
    .BITS        (`SPS_BITS_PER_CMD)
  )
  u_engine_b
  (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .startCmd  (startB),
    .doTx      (goTxB),
    .doRx      (goRxB),
    .intClock  (ctrlB[`SPS_MODE_HI:`SPS_MODE_LO] == `SPS_MODE_INTCLK),
    .txByte    (txDataB),
    .busy      (busyB),
    .done      (doneB),
    .rxByte    (rxByteB),
    .clkPinIn  (portBBit0ClockPinIn),
    .rxIn      (rxPick(ctrlB, rxS2[2], rxS2[3])),
    .txd       (txdB),
    .clkPinOut (portBBit0ClockPinOut),
    .clkPinOe  (portBBit0ClockPinOe)
  );

endmodule

/* File: hdl/sps_shift_engine.v */
`timescale 1ns/100ps
`include "sps_regs.vh"

module sps_shift_engine
#(
  parameter [15:0] HALF_CYCLES = 16'h0004,
  parameter [3:0]  BITS        = `SPS_BITS_PER_CMD
)
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // command side
  input  wire       startCmd,
  input  wire       doTx,
  input  wire       doRx,
  input  wire       intClock,
  input  wire [7:0] txByte,
  output reg        busy,
  output reg        done,
  output reg  [7:0] rxByte,
  // link side
  input  wire       clkPinIn,
  input  wire       rxIn,
  output reg        txd,
  output reg        clkPinOut,
  output reg        clkPinOe
);

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  reg  [1:0]  state;
  reg  [3:0]  bitCnt;
  reg  [15:0] divCnt;
  reg  [7:0]  txShift;
  reg  [7:0]  rxShift;
  reg         useTx;
  reg         useRx;
  reg         useInt;
  reg         clkS1;
  reg         clkS2;
  reg         clkS3;

  // clock pin synchroniser; third stage only feeds edge detection
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      clkS1 <= 1'b1;
      clkS2 <= 1'b1;
      clkS3 <= 1'b1;
    end
    else
    begin
      clkS1 <= clkPinIn;
      clkS2 <= clkS1;
      clkS3 <= clkS2;
    end
  end

  // edges of whichever clock drives the transfer
  wire tick     = (divCnt == HALF_CYCLES - 16'h0001);
  wire edgeRise = useInt ? (tick & ~clkPinOut) : (clkS2 & ~clkS3);
  wire edgeFall = useInt ? (tick & clkPinOut) : (~clkS2 & clkS3);

  // one command, eight bits, then idle again
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      busy      <= 1'b0;
      done      <= 1'b0;
      bitCnt    <= 4'h0;
      divCnt    <= 16'h0000;
      txShift   <= 8'hff;
      rxShift   <= 8'h00;
      rxByte    <= 8'h00;
      useTx     <= 1'b0;
      useRx     <= 1'b0;
      useInt    <= 1'b0;
      txd       <= 1'b1;
      clkPinOut <= 1'b1;
      clkPinOe  <= 1'b0;
    end
    else
    begin
      done     <= 1'b0;
      clkPinOe <= intClock;
      case (state)
        ST_IDLE:
        begin
          divCnt    <= 16'h0000;
          clkPinOut <= 1'b1;
          // line goes high a cycle after the last rise, keeping hold for the far side
          txd       <= 1'b1;
          if (startCmd)
          begin
            state   <= ST_SHIFT;
            busy    <= 1'b1;
            bitCnt  <= 4'h0;
            useTx   <= doTx;
            useRx   <= doRx;
            useInt  <= intClock;
            txShift <= txByte;
            txd     <= doTx ? txByte[0] : 1'b1;
          end
        end
        ST_SHIFT:
        begin
          // own clock: idle high, falls first, rises mid-bit
          if (useInt)
          begin
            if (tick)
            begin
              divCnt    <= 16'h0000;
              clkPinOut <= ~clkPinOut;
            end
            else
              divCnt <= divCnt + 16'h0001;
          end
          // next bit goes out on the falling edge, first one is preloaded
          if (edgeFall && bitCnt != 4'h0)
            txd <= useTx ? txShift[0] : 1'b1;
          // sample on the rising edge, lsb first
          if (edgeRise)
          begin
            txShift <= {1'b1, txShift[7:1]};
            if (useRx)
              rxShift <= {rxIn, rxShift[7:1]};
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == BITS - 4'h1)
            begin
              state <= ST_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
              if (useRx)
                rxByte <= {rxIn, rxShift[7:1]};
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule
